// *** design/pci_post_pkg.sv ***
// Constants and types for the PCI write-posting host port
package pci_post_pkg;

    localparam int          POST_DEPTH  = 64;
    localparam int          EXT_DEPTH   = 65472;
    localparam logic [23:0] LFB_OFS     = 24'h40_0000;
    localparam logic [23:0] TEX_OFS     = 24'h80_0000;
    localparam logic [3:0]  CMD_MEM_RD  = 4'h6;
    localparam logic [3:0]  CMD_MEM_WR  = 4'h7;
    localparam logic [3:0]  CMD_CFG_RD  = 4'ha;
    localparam logic [3:0]  CMD_CFG_WR  = 4'hb;
    localparam logic [3:0]  CMD_MEM_RM  = 4'hc;
    localparam logic [3:0]  CMD_MEM_RL  = 4'he;
    localparam logic [3:0]  CMD_MEM_WI  = 4'hf;
    localparam logic [5:0]  CFG_ID_IDX  = 6'h00;
    localparam logic [5:0]  CFG_CMD_IDX = 6'h01;
    localparam logic [5:0]  CFG_BAR_IDX = 6'h04;
    localparam int          MEM_EN_BIT  = 1;
    localparam logic [3:0]  BAR_TYPE    = 4'h0;
    localparam logic [7:0]  BASE_RST    = 8'h00;
    localparam logic [23:0] ADDR_STEP   = 24'h00_0004;

    typedef enum logic [3:0] {
        DEST_REG  = 4'b0001,
        DEST_LFB  = 4'b0010,
        DEST_PIPE = 4'b0100,
        DEST_TEX  = 4'b1000
    } dest_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
    } post_entry_t;

    typedef enum logic [6:0] {
        T_IDLE  = 7'b0000001,
        T_WRITE = 7'b0000010,
        T_RETRY = 7'b0000100,
        T_CFGW  = 7'b0001000,
        T_CFGR  = 7'b0010000,
        T_CFGD  = 7'b0100000,
        T_DONE  = 7'b1000000
    } tgt_state_t;

endpackage : pci_post_pkg

// *** design/pci_write_posting_host_port.sv ***
// PCI target port that posts host writes into the graphics clock domain
`timescale 1ns/100ps

module post_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstN,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk)
    begin
        s1_reg <= d;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // Only a settled value passes; a pointer seen moving is held back, which is safe
    always_ff @(posedge clk)
    begin
        if (!rstN)
            q_reg <= '0;
        else if (s2_reg == s3_reg)
            q_reg <= s3_reg;
    end

    assign q = q_reg;
endmodule : post_sync

module pci_write_posting_host_port #(
    parameter int          DEPTH  = pci_post_pkg::POST_DEPTH,
    parameter int          EXT    = pci_post_pkg::EXT_DEPTH,
    parameter logic [31:0] DEV_ID = 32'h1234_5678, // Arbitrary identity value
    localparam int         EW     = $clog2(EXT + 1)
) (
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic                     pciClk,
    input  wire logic [31:0]              adIn,
    output logic      [31:0]              adOut,
    output logic                          adOe,
    input  wire logic [3:0]               cbeN,
    output logic                          parOut,
    output logic                          parOe,
    input  wire logic                     frameN,
    input  wire logic                     irdyN,
    input  wire logic                     idsel,
    output logic                          devselN,
    output logic                          trdyN,
    output logic                          stopN,
    output logic                          ctlOe,
    input  wire logic                     extEnable,
    input  wire logic [EW-1:0]            extDepth,
    input  wire logic                     lfbPipeEnable,
    output logic                          outValid,
    output pci_post_pkg::dest_t           outDest,
    output pci_post_pkg::post_entry_t     outEntry,
    input  wire logic                     outReady,
    output logic      [EW-1:0]            extLevel
);
    localparam int PW = $clog2(DEPTH) + 1;
    localparam int XW = $clog2(EXT);

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--)
            b[i] = (i == PW - 1) ? g[i] : (b[i + 1] ^ g[i]);
        gray2bin = b;
    endfunction : gray2bin

    function automatic pci_post_pkg::dest_t destOf(input logic [23:0] a,
                                                   input logic        pipe);
        if (a >= pci_post_pkg::TEX_OFS)
            destOf = pci_post_pkg::DEST_TEX;
        else if (a >= pci_post_pkg::LFB_OFS)
            destOf = pipe ? pci_post_pkg::DEST_PIPE
                          : pci_post_pkg::DEST_LFB;
        else
            destOf = pci_post_pkg::DEST_REG;
    endfunction : destOf

    // Bus clock domain
    logic                      pciRstN;
    pci_post_pkg::tgt_state_t  state_reg;
    logic                      devselN_reg;
    logic                      trdyN_reg;
    logic                      stopN_reg;
    logic                      ctlOe_reg;
    logic [31:0]               adOut_reg;
    logic                      adOe_reg;
    logic                      parOut_reg;
    logic                      parOe_reg;
    logic                      frameDly_reg;
    logic [23:0]               addr_reg;
    logic [7:0]                base_reg;
    logic                      memEn_reg;
    logic [5:0]                cfgIdx_reg;
    logic [PW-1:0]             wptr_reg;
    logic [PW-1:0]             wgray_reg;
    logic [PW-1:0]             rgSync;
    logic [PW-1:0]             rptr_reg;
    logic [PW-1:0]             rgray_reg;
    pci_post_pkg::post_entry_t postMem [DEPTH];

    logic                      addrPhase;
    logic                      hitMem;
    logic                      cfgHit;
    logic                      isWr;
    logic                      isRd;
    logic                      xfer;
    logic                      push;
    logic                      ending;
    logic                      room;
    logic [PW-1:0]             fill;
    logic [31:0]               cfgData;

    post_sync #(.W(1)) rstSync (
        .clk  (pciClk),
        .rstN (1'b1),
        .d    (nrst),
        .q    (pciRstN)
    );

    post_sync #(.W(PW)) rptrSync (
        .clk  (pciClk),
        .rstN (pciRstN),
        .d    (rgray_reg),
        .q    (rgSync)
    );

    always_comb
    begin
        addrPhase = (state_reg == pci_post_pkg::T_IDLE) && !frameN && frameDly_reg;
        hitMem    = memEn_reg && (adIn[31:24] == base_reg);
        cfgHit    = idsel && (adIn[1:0] == 2'b00);
        // I/O commands never match any claim below
        isWr      = (cbeN == pci_post_pkg::CMD_MEM_WR) ||
                    (cbeN == pci_post_pkg::CMD_MEM_WI);
        isRd      = (cbeN == pci_post_pkg::CMD_MEM_RD) ||
                    (cbeN == pci_post_pkg::CMD_MEM_RM) ||
                    (cbeN == pci_post_pkg::CMD_MEM_RL);
        xfer      = !irdyN && !trdyN_reg;
        push      = (state_reg == pci_post_pkg::T_WRITE) && xfer;
        ending    = frameN && !irdyN;
        fill      = PW'(wptr_reg - gray2bin(rgSync));
        // Space left after this cycle's push decides the next ready
        room      = (fill + PW'(push)) < PW'(DEPTH);
    end

    always_comb
    begin
        case (cfgIdx_reg)
            pci_post_pkg::CFG_ID_IDX:
                cfgData = DEV_ID;
            pci_post_pkg::CFG_CMD_IDX:
                cfgData = 32'(memEn_reg) << pci_post_pkg::MEM_EN_BIT;
            pci_post_pkg::CFG_BAR_IDX:
                cfgData = {base_reg, 20'h0_0000, pci_post_pkg::BAR_TYPE};
            default:
                cfgData = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pciClk)
    begin
        frameDly_reg <= frameN;
    end

    // Target handshake; outputs are registered, decode is one clock (fast)
    always_ff @(posedge pciClk)
    begin
        if (!pciRstN)
        begin
            state_reg   <= pci_post_pkg::T_IDLE;
            devselN_reg <= 1'b1;
            trdyN_reg   <= 1'b1;
            stopN_reg   <= 1'b1;
            ctlOe_reg   <= 1'b0;
        end
        else
        begin
            case (state_reg)
                pci_post_pkg::T_IDLE:
                begin
                    ctlOe_reg <= 1'b0;
                    if (addrPhase && hitMem && isWr)
                    begin
                        state_reg   <= pci_post_pkg::T_WRITE;
                        devselN_reg <= 1'b0;
                        trdyN_reg   <= !room;
                        ctlOe_reg   <= 1'b1;
                    end
                    else if (addrPhase && hitMem && isRd)
                    begin
                        // Reads are not served: target retry
                        state_reg   <= pci_post_pkg::T_RETRY;
                        devselN_reg <= 1'b0;
                        stopN_reg   <= 1'b0;
                        ctlOe_reg   <= 1'b1;
                    end
                    else if (addrPhase && cfgHit && cbeN == pci_post_pkg::CMD_CFG_WR)
                    begin
                        state_reg   <= pci_post_pkg::T_CFGW;
                        devselN_reg <= 1'b0;
                        trdyN_reg   <= 1'b0;
                        stopN_reg   <= 1'b0;
                        ctlOe_reg   <= 1'b1;
                    end
                    else if (addrPhase && cfgHit && cbeN == pci_post_pkg::CMD_CFG_RD)
                    begin
                        state_reg   <= pci_post_pkg::T_CFGR;
                        devselN_reg <= 1'b0;
                        ctlOe_reg   <= 1'b1;
                    end
                end
                pci_post_pkg::T_WRITE:
                begin
                    if (xfer && frameN)
                    begin
                        state_reg   <= pci_post_pkg::T_DONE;
                        devselN_reg <= 1'b1;
                        trdyN_reg   <= 1'b1;
                    end
                    else
                        trdyN_reg   <= !room;
                end
                pci_post_pkg::T_CFGR:
                begin
                    // Turnaround cycle passed, data goes out now
                    state_reg <= pci_post_pkg::T_CFGD;
                    trdyN_reg <= 1'b0;
                    stopN_reg <= 1'b0;
                end
                pci_post_pkg::T_RETRY, pci_post_pkg::T_CFGW, pci_post_pkg::T_CFGD:
                begin
                    // At most one data phase (none on retry), then disconnect
                    if (ending)
                    begin
                        state_reg   <= pci_post_pkg::T_DONE;
                        devselN_reg <= 1'b1;
                        trdyN_reg   <= 1'b1;
                        stopN_reg   <= 1'b1;
                    end
                    else if (xfer)
                        trdyN_reg   <= 1'b1;
                end
                pci_post_pkg::T_DONE:
                begin
                    // Lines were driven high one clock before release
                    state_reg <= pci_post_pkg::T_IDLE;
                    ctlOe_reg <= 1'b0;
                end
                default:
                begin
                    state_reg   <= pci_post_pkg::T_IDLE;
                    devselN_reg <= 1'b1;
                    trdyN_reg   <= 1'b1;
                    stopN_reg   <= 1'b1;
                    ctlOe_reg   <= 1'b0;
                end
            endcase
        end
    end

    // Configuration space
    always_ff @(posedge pciClk)
    begin
        if (!pciRstN)
        begin
            base_reg   <= pci_post_pkg::BASE_RST;
            memEn_reg  <= 1'b0;
            cfgIdx_reg <= 6'h00;
        end
        else
        begin
            if (addrPhase)
                cfgIdx_reg <= adIn[7:2];
            if (state_reg == pci_post_pkg::T_CFGW && xfer)
            begin
                if (cfgIdx_reg == pci_post_pkg::CFG_BAR_IDX && !cbeN[3])
                    base_reg <= adIn[31:24];
                if (cfgIdx_reg == pci_post_pkg::CFG_CMD_IDX && !cbeN[0])
                    memEn_reg <= adIn[pci_post_pkg::MEM_EN_BIT];
            end
        end
    end

    // Read data and parity, parity trails the data by one clock
    always_ff @(posedge pciClk)
    begin
        if (!pciRstN)
        begin
            adOut_reg  <= 32'h0000_0000;
            adOe_reg   <= 1'b0;
            parOut_reg <= 1'b0;
            parOe_reg  <= 1'b0;
        end
        else
        begin
            adOe_reg   <= (state_reg == pci_post_pkg::T_CFGR) ||
                          (state_reg == pci_post_pkg::T_CFGD && !ending);
            adOut_reg  <= cfgData;
            parOut_reg <= ^{adOut_reg, cbeN};
            parOe_reg  <= adOe_reg;
        end
    end

    // Posting queue write side
    always_ff @(posedge pciClk)
    begin
        if (!pciRstN)
        begin
            wptr_reg  <= '0;
            wgray_reg <= '0;
            addr_reg  <= 24'h00_0000;
        end
        else
        begin
            if (addrPhase)
                addr_reg <= {adIn[23:2], 2'b00};
            else if (push)
                addr_reg <= addr_reg + pci_post_pkg::ADDR_STEP;
            if (push)
            begin
                wptr_reg  <= wptr_reg + 1'b1;
                wgray_reg <= bin2gray(wptr_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge pciClk)
    begin
        if (push)
            postMem[wptr_reg[PW-2:0]] <= '{addr_reg, adIn, ~cbeN};
    end

    // Graphics clock domain
    logic [PW-1:0]             wgSync;
    logic [EW-1:0]             extCount_reg;
    logic [XW-1:0]             extWr_reg;
    logic [XW-1:0]             extRd_reg;
    logic                      outValid_reg;
    pci_post_pkg::dest_t       outDest_reg;
    pci_post_pkg::post_entry_t outEntry_reg;
    pci_post_pkg::post_entry_t extMem [EXT];

    logic                      empty;
    logic                      useExt;
    logic                      outFree;
    logic                      pop;
    logic                      extPush;
    logic                      extPop;
    logic [EW-1:0]             extLimit;
    pci_post_pkg::post_entry_t head;

    post_sync #(.W(PW)) wptrSync (
        .clk  (mclk),
        .rstN (nrst),
        .d    (wgray_reg),
        .q    (wgSync)
    );

    always_comb
    begin
        empty    = rgray_reg == wgSync;
        head     = postMem[rptr_reg[PW-2:0]];
        // Once used, the extension drains fully before bypass resumes
        useExt   = extEnable || (extCount_reg != '0);
        extLimit = (extDepth > EW'(EXT)) ? EW'(EXT) : extDepth;
        outFree  = !outValid_reg || outReady;
        pop      = !empty && (useExt ? (extCount_reg < extLimit) : outFree);
        extPush  = pop && useExt;
        extPop   = (extCount_reg != '0) && outFree;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            rptr_reg  <= '0;
            rgray_reg <= '0;
        end
        else if (pop)
        begin
            rptr_reg  <= rptr_reg + 1'b1;
            rgray_reg <= bin2gray(rptr_reg + 1'b1);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            extCount_reg <= '0;
            extWr_reg    <= '0;
            extRd_reg    <= '0;
        end
        else
        begin
            if (extPush)
                extWr_reg <= (extWr_reg == XW'(EXT - 1)) ? '0 : extWr_reg + 1'b1;
            if (extPop)
                extRd_reg <= (extRd_reg == XW'(EXT - 1)) ? '0 : extRd_reg + 1'b1;
            if (extPush && !extPop)
                extCount_reg <= extCount_reg + 1'b1;
            else if (extPop && !extPush)
                extCount_reg <= extCount_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (extPush)
            extMem[extWr_reg] <= head;
    end

    // Output stage, one entry held until taken
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            outValid_reg <= 1'b0;
            outDest_reg  <= pci_post_pkg::DEST_REG;
            outEntry_reg <= '0;
        end
        else if (extPop)
        begin
            outValid_reg <= 1'b1;
            outEntry_reg <= extMem[extRd_reg];
            outDest_reg  <= destOf(extMem[extRd_reg].addr, lfbPipeEnable);
        end
        else if (pop && !useExt)
        begin
            outValid_reg <= 1'b1;
            outEntry_reg <= head;
            outDest_reg  <= destOf(head.addr, lfbPipeEnable);
        end
        else if (outReady)
            outValid_reg <= 1'b0;
    end

    // Byte enables are passed on; register writes are assumed whole words
    assign outEntry = outEntry_reg;
    assign outValid = outValid_reg;
    assign outDest  = outDest_reg;
    assign extLevel = extCount_reg;
    assign adOut    = adOut_reg;
    assign adOe     = adOe_reg;
    assign parOut   = parOut_reg;
    assign parOe    = parOe_reg;
    assign devselN  = devselN_reg;
    assign trdyN    = trdyN_reg;
    assign stopN    = stopN_reg;
    assign ctlOe    = ctlOe_reg;

endmodule : pci_write_posting_host_port

// *** dv/pci_master_model.sv ***
// Behavioural bus master facing the host port
`timescale 1ns/100ps
module pci_master_model (
    input  wire logic        pciClk,
    input  wire logic [31:0] adBus,
    input  wire logic        devselN,
    input  wire logic        trdyN,
    input  wire logic        stopN,
    output logic             frameN,
    output logic             irdyN,
    output logic             idsel,
    output logic      [3:0]  cbeN,
    output logic      [31:0] adDrv
);
    logic [31:0] wq[$];
    logic [3:0]  bq[$];
    int          waits = 0;
    initial
    begin
        frameN = 1'b1;
        irdyN = 1'b1;
        idsel = 1'b0;
        cbeN = 4'hf;
        adDrv = 32'h0000_0000;
    end
    // Status: 0 done, 1 retried, 2 no claim, 3 hung
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
                        input int n, output logic [31:0] rd, output int st);
        int k;
        st = -1;
        rd = 32'h0000_0000;
        @(posedge pciClk);
        #1;
        frameN = 1'b0;
        idsel = sel;
        cbeN = cmd;
        adDrv = addr;
        @(posedge pciClk);
        for (int i = 0; i < n && st < 0; i++)
        begin
            #1;
            frameN = (i == n - 1);
            irdyN = 1'b0;
            cbeN = cmd[0] ? bq.pop_front() : 4'h0;
            // Released AD shows the inverse, never a stale copy
            adDrv = cmd[0] ? wq.pop_front() : ~adDrv;
            k = 0;
            do
            begin
                @(posedge pciClk);
                k++;
            end
            while (trdyN && stopN && k < 1000 && !(devselN && k > 4));
            rd = adBus;
            waits += k - 1;
            if (devselN) st = 2;
            else if (trdyN) st = stopN ? 3 : 1;
            else if (!stopN || i == n - 1) st = 0;
        end
        #1;
        if (!frameN)
        begin
            frameN = 1'b1;
            @(posedge pciClk);
            #1;
        end
        irdyN = 1'b1;
        idsel = 1'b0;
        cbeN = 4'hf;
        adDrv = ~adDrv;
        @(posedge pciClk);
    endtask : xfer
endmodule : pci_master_model

// *** dv/pci_write_posting_host_port_asserts.sv ***
// Pin-level checks for the write-posting host port
`timescale 1ns/100ps
module pci_write_posting_host_port_asserts (
    input wire logic                      mclk,
    input wire logic                      nrst,
    input wire logic                      pciClk,
    input wire logic [31:0]               adOut,
    input wire logic                      adOe,
    input wire logic [3:0]                cbeN,
    input wire logic                      parOut,
    input wire logic                      parOe,
    input wire logic                      frameN,
    input wire logic                      devselN,
    input wire logic                      trdyN,
    input wire logic                      stopN,
    input wire logic                      ctlOe,
    input wire logic                      outValid,
    input wire pci_post_pkg::dest_t       outDest,
    input wire pci_post_pkg::post_entry_t outEntry,
    input wire logic                      outReady
);
    a_par_lag:
    assert property (@(posedge pciClk) disable iff (!nrst) parOe == $past(adOe))
        else $error("parity lag");
    a_par_even:
    assert property (@(posedge pciClk) disable iff (!nrst)
        parOe |-> parOut == ^{$past(adOut), $past(cbeN)}) else $error("parity wrong");
    a_io_ignored:
    assert property (@(posedge pciClk) disable iff (!nrst)
        $fell(frameN) && cbeN[3:1] == 3'b001 |=> devselN [*3]) else $error("io claimed");
    a_devsel_fast:
    assert property (@(posedge pciClk) disable iff (!nrst)
        $fell(devselN) |-> !$past(frameN) && $past(frameN, 2)) else $error("devsel timing");
    a_ad_claimed:
    assert property (@(posedge pciClk) disable iff (!nrst)
        adOe |-> !devselN && ctlOe) else $error("ad driven unclaimed");
    a_trdy_claimed:
    assert property (@(posedge pciClk) disable iff (!nrst)
        !trdyN |-> !devselN && ctlOe) else $error("trdy without devsel");
    a_ctl_turn:
    assert property (@(posedge pciClk) disable iff (!nrst)
        $rose(devselN) |-> ctlOe ##1 !ctlOe) else $error("turnaround");
    a_read_retry:
    assert property (@(posedge pciClk) disable iff (!nrst)
        $fell(frameN) && cbeN == pci_post_pkg::CMD_MEM_RD
        |=> (devselN || (!stopN && trdyN)) [*2]) else $error("no retry");
    a_out_hold:
    assert property (@(posedge mclk) disable iff (!nrst) outValid && !outReady
        |=> outValid && $stable(outEntry) && $stable(outDest)) else $error("entry moved");
    a_dest_map:
    assert property (@(posedge mclk) disable iff (!nrst) outValid |->
        (outEntry.addr[23] ? outDest == pci_post_pkg::DEST_TEX : outEntry.addr[22]
        ? outDest inside {pci_post_pkg::DEST_LFB, pci_post_pkg::DEST_PIPE}
        : outDest == pci_post_pkg::DEST_REG)) else $error("bad dest");
endmodule : pci_write_posting_host_port_asserts

bind pci_write_posting_host_port pci_write_posting_host_port_asserts chk_inst (
    .mclk, .nrst, .pciClk, .adOut, .adOe, .cbeN, .parOut, .parOe, .frameN, .devselN,
    .trdyN, .stopN, .ctlOe, .outValid, .outDest, .outEntry, .outReady);

// *** dv/tb_pci_write_posting_host_port.sv ***
// Self-checking bench for the write-posting host port
`timescale 1ns/100ps
module tb_pci_write_posting_host_port;
    localparam int EXT = 8;
    localparam int EW  = $clog2(EXT + 1);
    logic                      mclk = 1'b0, pciClk = 1'b0, nrst = 1'b0;
    logic                      frameN, irdyN, idsel, devselN, trdyN, stopN;
    logic                      adOe, parOut, parOe, ctlOe, outValid;
    logic                      extEnable = 1'b0, lfbPipeEnable = 1'b0;
    logic                      outReady = 1'b0, drain = 1'b0;
    logic [3:0]                cbeN;
    logic [31:0]               adBus, adOut, adDrv, rd;
    logic [EW-1:0]             extDepth = EW'(EXT), extLevel;
    logic [23:0]               ofsTab[5] = '{24'h00_0000, 24'h3f_fffc, 24'h7f_fffc,
                                             24'h80_0000, 24'hff_fffc};
    pci_post_pkg::dest_t       outDest, destQ[$];
    pci_post_pkg::post_entry_t outEntry, expQ[$];
    int                        miscompares = 0, numChecks = 0, st, w0;
    initial forever #12.5 mclk = ~mclk;
    initial
    begin
        #7;
        forever #15 pciClk = ~pciClk;
    end
    assign adBus = adOe ? adOut : adDrv;
    pci_master_model pci_master_model_inst (.pciClk, .adBus, .devselN, .trdyN, .stopN,
        .frameN, .irdyN, .idsel, .cbeN, .adDrv);
    pci_write_posting_host_port #(.DEPTH(4), .EXT(EXT)) pci_write_posting_host_port_inst (
        .mclk, .nrst, .pciClk, .adIn(adBus), .adOut, .adOe, .cbeN, .parOut, .parOe, .frameN,
        .irdyN, .idsel, .devselN, .trdyN, .stopN, .ctlOe, .extEnable, .extDepth,
        .lfbPipeEnable, .outValid, .outDest, .outEntry, .outReady, .extLevel);
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        numChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    function automatic pci_post_pkg::dest_t dest_of(input logic [23:0] a);
        if (a[23]) return pci_post_pkg::DEST_TEX;
        if (a[22]) return lfbPipeEnable ? pci_post_pkg::DEST_PIPE : pci_post_pkg::DEST_LFB;
        return pci_post_pkg::DEST_REG;
    endfunction : dest_of
    // Consumer with random stalls; compares each taken entry in order
    always @(posedge mclk)
    begin
        if (outValid === 1'b1 && outReady === 1'b1)
        begin
            chk(expQ.size() > 0, 1'b1, "unexpected entry");
            chk(outEntry, expQ.pop_front(), "entry content");
            chk(outDest, destQ.pop_front(), "entry destination");
        end
        #1 outReady = drain & 1'($urandom);
    end
    task automatic wr(input logic [3:0] cmd, input logic [31:0] a, input int n, input int ex);
        pci_post_pkg::post_entry_t e;
        for (int i = 0; i < n; i++)
        begin
            e.addr = a[23:0] + 24'(i) * pci_post_pkg::ADDR_STEP;
            e.data = $urandom;
            e.be = (e.addr[23:22] == 2'b00) ? 4'hf : 4'($urandom);
            pci_master_model_inst.wq.push_back(e.data);
            pci_master_model_inst.bq.push_back(~e.be);
            if (ex == 0) expQ.push_back(e);
            if (ex == 0) destQ.push_back(dest_of(e.addr));
        end
        pci_master_model_inst.xfer(cmd, a, 1'b0, n, rd, st);
        chk(st, ex, "bus cycle ending");
        if (st == 3) report_and_stop();
    endtask : wr
    task automatic cfg(input logic [3:0] cmd, input logic [5:0] idx, input logic [31:0] d);
        if (cmd[0]) pci_master_model_inst.wq.push_back(d);
        if (cmd[0]) pci_master_model_inst.bq.push_back(4'h0);
        pci_master_model_inst.xfer(cmd, {24'h00_0000, idx, 2'b00}, 1'b1, 1, rd, st);
    endtask : cfg
    task automatic wait_empty(input string name);
        for (int k = 0; k < 3000 && expQ.size() > 0; k++) @(posedge mclk);
        chk(expQ.size(), 0, "entries not delivered");
        if (expQ.size() > 0) report_and_stop();
        $display("test %s done", name);
    endtask : wait_empty
    initial
    begin
        void'($urandom(32'h798b_b4a0));
        repeat (8) @(posedge pciClk);
        #1 nrst = 1'b1;
        repeat (8) @(posedge pciClk);
        chk(ctlOe, 1'b0, "bus idle after reset");
        chk(outValid, 1'b0, "stream idle after reset");
        cfg(pci_post_pkg::CMD_CFG_WR, pci_post_pkg::CFG_BAR_IDX, 32'h5a00_0000);
        cfg(pci_post_pkg::CMD_CFG_WR, pci_post_pkg::CFG_CMD_IDX, 32'h0000_0002);
        cfg(pci_post_pkg::CMD_CFG_RD, pci_post_pkg::CFG_BAR_IDX, 32'h0000_0000);
        chk(rd, 32'h5a00_0000, "window base readback");
        drain = 1'b1;
        // Bursts at region edges, three of them crossing one; the last one wraps to offset zero
        foreach (ofsTab[j])
        begin
            lfbPipeEnable = j[0];
            wr(j[0] ? pci_post_pkg::CMD_MEM_WI : pci_post_pkg::CMD_MEM_WR,
               {8'h5a, ofsTab[j]}, 3, 0);
            wait_empty("decode");
        end
        wr(4'h3, 32'h5a00_0000, 1, 2);
        wr(pci_post_pkg::CMD_MEM_WR, 32'h5b00_0000, 1, 2);
        pci_master_model_inst.xfer(pci_post_pkg::CMD_MEM_RD, 32'h5a40_0000, 1'b0, 2, rd, st);
        chk(st, 1, "read retried");
        drain = 1'b0;
        w0 = pci_master_model_inst.waits;
        fork
            wr(pci_post_pkg::CMD_MEM_WR, 32'h5a80_0000, 8, 0);
            begin
                repeat (300) @(posedge mclk);
                #1 drain = 1'b1;
            end
        join
        chk(pci_master_model_inst.waits > w0, 1'b1, "wait states when full");
        wait_empty("full");
        extEnable = 1'b1;
        drain = 1'b0;
        fork
            wr(pci_post_pkg::CMD_MEM_WR, 32'h5a40_0100, 12, 0);
            begin
                repeat (400) @(posedge mclk);
                chk(extLevel != 0, 1'b1, "extension holds entries");
                #1 drain = 1'b1;
            end
        join
        wait_empty("extension");
        report_and_stop();
    end
endmodule : tb_pci_write_posting_host_port
